// >>> dsm_supply_manager.sv
// dual supply mode manager: mode state, switch pin, plug interrupt, media regulator
`timescale 1ns/1ps
`include "dsm_defines.svh"
module dsm_supply_manager (
	input  wire logic                ref_clk_i,
	input  wire logic                rst_i,
	input  wire logic                sw_reset_i,
	input  wire logic                usb_supply_above_upper_i,
	input  wire logic                usb_supply_above_lower_i,
	input  wire logic                option_switch_pin_i,
	input  wire logic                plug_irq_enable_i,
	input  wire logic [1:0]          regulator_voltage_select_i,
	input  wire logic                detector_disable_i,
	input  wire logic                regulator_enable_i,
	input  wire logic                switch_pin_alt_io_out_i,
	input  wire logic                switch_pin_alt_io_oe_i,
	input  wire logic                switch_pin_in_i,
	output logic                     switch_pin_alt_io_in_o,
	output logic                     supply_switch_enable_out_o,
	output logic                     supply_switch_enable_oe_o,
	output logic                     plug_irq_o,
	output logic [7:0]               power_control_reg_o,
	output logic                     usb_mode_o,
	output logic                     io_hiz_o,
	output logic                     clk_from_xtal_div_o,
	output dsm_pkg::dsm_clk_cfg_s    clk_cfg_o,
	output logic                     regulator_on_o,
	output logic [11:0]              regulator_mv_o
);
	////////////////////////////////////////////////////////////////////////////////
	// three-stage input sync; change counts when stages two and three agree
	logic [2:0] up_sync_reg;
	logic [2:0] lo_sync_reg;
	logic [2:0] pin_sync_reg;
	logic       up_filt_reg;
	logic       lo_filt_reg;
	logic       pin_filt_reg;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			up_sync_reg  <= 3'h0;
			lo_sync_reg  <= 3'h0;
			pin_sync_reg <= 3'h0;
		end else begin
			up_sync_reg  <= {up_sync_reg[1:0], usb_supply_above_upper_i};
			lo_sync_reg  <= {lo_sync_reg[1:0], usb_supply_above_lower_i};
			pin_sync_reg <= {pin_sync_reg[1:0], switch_pin_in_i};
		end
	end
	wire up_agree  = (up_sync_reg[2] == up_sync_reg[1]);
	wire lo_agree  = (lo_sync_reg[2] == lo_sync_reg[1]);
	wire pin_agree = (pin_sync_reg[2] == pin_sync_reg[1]);
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			up_filt_reg  <= 1'b0;
			lo_filt_reg  <= 1'b0;
			pin_filt_reg <= 1'b0;
		end else begin
			if (up_agree)
				up_filt_reg <= up_sync_reg[2];
			if (lo_agree)
				lo_filt_reg <= lo_sync_reg[2];
			if (pin_agree)
				pin_filt_reg <= pin_sync_reg[2];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// plug detect with hysteresis; a disabled detector forces the flags high
	logic plug_reg;
	logic plug_next;
	wire  itp_flag = detector_disable_i | up_filt_reg;
	wire  itm_flag = detector_disable_i | lo_filt_reg;
	always_comb begin
		plug_next = plug_reg;
		if (itp_flag)
			plug_next = 1'b1;
		else if (!itm_flag)
			plug_next = 1'b0;
	end
	always_ff @(posedge ref_clk_i) begin
		if (rst_i)
			plug_reg <= 1'b0;
		else
			plug_reg <= plug_next;
	end

	////////////////////////////////////////////////////////////////////////////////
	// mode state; mode changes only across a software reset, but the clock still
	// switches at once when dual_supply changes while the mode is stand-alone
	dsm_pkg::dsm_mode_e mode_reg;
	dsm_pkg::dsm_mode_e mode_next;
	logic               init_reg;
	wire dual_supply = option_switch_pin_i & plug_irq_enable_i;
	always_comb begin
		mode_next = mode_reg;
		if (init_reg)
			mode_next = plug_reg ? dsm_pkg::DSM_ST_USB : dsm_pkg::DSM_ST_STANDALONE;
		else begin
			case (mode_reg)
				dsm_pkg::DSM_ST_STANDALONE:
					if (sw_reset_i && plug_reg)
						mode_next = dsm_pkg::DSM_ST_TO_USB;
				dsm_pkg::DSM_ST_TO_USB:
					if (!sw_reset_i)
						mode_next = dsm_pkg::DSM_ST_USB;
				dsm_pkg::DSM_ST_USB:
					if (sw_reset_i && !plug_reg && dual_supply)
						mode_next = dsm_pkg::DSM_ST_TO_SA;
				dsm_pkg::DSM_ST_TO_SA:
					if (!sw_reset_i)
						mode_next = dsm_pkg::DSM_ST_STANDALONE;
				default:
					mode_next = dsm_pkg::DSM_ST_STANDALONE;
			endcase
		end
	end
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			mode_reg <= dsm_pkg::DSM_ST_STANDALONE;
			init_reg <= 1'b1;
		end else begin
			mode_reg <= mode_next;
			init_reg <= 1'b0;
		end
	end
	// single supply treats the part as always in usb mode
	wire in_usb = (mode_reg == dsm_pkg::DSM_ST_USB) || (mode_reg == dsm_pkg::DSM_ST_TO_USB)
		|| !dual_supply;
	wire in_reset = (mode_reg == dsm_pkg::DSM_ST_TO_USB) || (mode_reg == dsm_pkg::DSM_ST_TO_SA)
		|| sw_reset_i;

	////////////////////////////////////////////////////////////////////////////////
	// plug interrupt on upper rise or plug rise outside usb mode, on lower fall in usb mode, gated by plug enable
	logic itp_d_reg;
	logic itm_d_reg;
	logic irq_reg;
	wire  rise_upper = itp_flag & ~itp_d_reg;
	wire  fall_lower = ~itm_flag & itm_d_reg;
	wire  plug_rise  = plug_next & ~plug_reg;
	wire  irq_set    = plug_irq_enable_i & ((!in_usb & (rise_upper | plug_rise))
		| (in_usb & fall_lower));
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			itp_d_reg <= 1'b0;
			itm_d_reg <= 1'b0;
			irq_reg   <= 1'b0;
		end else begin
			itp_d_reg <= itp_flag;
			itm_d_reg <= itm_flag;
			// set wins over clear; the software reset that answers it clears it
			irq_reg   <= irq_set | (irq_reg & ~sw_reset_i & plug_irq_enable_i);
		end
	end
	assign plug_irq_o = irq_reg;

	////////////////////////////////////////////////////////////////////////////////
	// clock plan, usb interface and switch pin
	wire usb_drive = dual_supply & in_usb;
	always_comb begin
		clk_cfg_o.pll_on        = in_usb;
		clk_cfg_o.pll_mhz       = in_usb ? `DSM_PLL_MHZ : 8'h00;
		clk_cfg_o.usb_if_enable = in_usb & ~in_reset;
		clk_cfg_o.core_max_mhz  = in_usb ? `DSM_CORE_MAX_USB : `DSM_CORE_MAX_SA;
	end
	assign clk_from_xtal_div_o        = ~in_usb;
	assign usb_mode_o                 = in_usb;
	assign io_hiz_o                   = in_reset;
	// option not selected: pin is plain io, but still floats during reset
	assign supply_switch_enable_out_o = option_switch_pin_i ? 1'b0 : switch_pin_alt_io_out_i;
	assign supply_switch_enable_oe_o  = option_switch_pin_i ? usb_drive
		: (switch_pin_alt_io_oe_i & ~in_reset);
	assign switch_pin_alt_io_in_o     = pin_filt_reg;

	////////////////////////////////////////////////////////////////////////////////
	// media regulator; enable is left to software in every mode
	logic [11:0] mv_sel;
	always_comb begin
		case (regulator_voltage_select_i)
			`DSM_VSEL_3V5: mv_sel = `DSM_MV_3V5;
			`DSM_VSEL_3V4: mv_sel = `DSM_MV_3V4;
			`DSM_VSEL_3V3: mv_sel = `DSM_MV_3V3;
			`DSM_VSEL_2V8: mv_sel = `DSM_MV_2V8;
			default:       mv_sel = `DSM_MV_3V5;
		endcase
	end
	assign regulator_on_o = regulator_enable_i;
	assign regulator_mv_o = regulator_enable_i ? mv_sel : 12'h000;

	////////////////////////////////////////////////////////////////////////////////
	// status image of the power control byte
	always_comb begin
		power_control_reg_o                      = `DSM_PWR_CTRL_RESET;
		power_control_reg_o[`DSM_BIT_ITPF]       = itp_flag;
		power_control_reg_o[`DSM_BIT_ITMF]       = itm_flag;
		power_control_reg_o[`DSM_BIT_PLUG]       = plug_reg;
		power_control_reg_o[`DSM_BIT_PLUG_IRQEN] = plug_irq_enable_i;
		power_control_reg_o[`DSM_BIT_VSEL_HI] = regulator_voltage_select_i[1];
		power_control_reg_o[`DSM_BIT_VSEL_LO] = regulator_voltage_select_i[0];
		power_control_reg_o[`DSM_BIT_DETEN]   = detector_disable_i;
		power_control_reg_o[`DSM_BIT_REG_ON]  = regulator_enable_i;
	end
endmodule

// >>> dsm_defines.svh
// constants for the dual supply mode manager
`ifndef DSM_DEFINES_SVH
`define DSM_DEFINES_SVH
`define DSM_PWR_CTRL_RESET 8'h00
`define DSM_BIT_ITPF       7
`define DSM_BIT_ITMF       6
`define DSM_BIT_PLUG       5
`define DSM_BIT_PLUG_IRQEN 4
`define DSM_BIT_VSEL_HI    3
`define DSM_BIT_VSEL_LO    2
`define DSM_BIT_DETEN      1
`define DSM_BIT_REG_ON     0
`define DSM_VSEL_3V5       2'h0
`define DSM_VSEL_3V4       2'h1
`define DSM_VSEL_3V3       2'h2
`define DSM_VSEL_2V8       2'h3
`define DSM_MV_3V5         12'hDAC
`define DSM_MV_3V4         12'hD48
`define DSM_MV_3V3         12'hCE4
`define DSM_MV_2V8         12'hAF0
`define DSM_PLL_MHZ        8'h30
`define DSM_CORE_MAX_USB   4'h8
`define DSM_CORE_MAX_SA    4'h6
`endif

// >>> dsm_pkg.sv
// types for the dual supply mode manager
package dsm_pkg;
	typedef enum logic [1:0] {
		DSM_ST_STANDALONE = 2'h0,
		DSM_ST_TO_USB     = 2'h1,
		DSM_ST_USB        = 2'h3,
		DSM_ST_TO_SA      = 2'h2
	} dsm_mode_e;

	typedef struct packed {
		logic       pll_on;
		logic [7:0] pll_mhz;
		logic       usb_if_enable;
		logic [3:0] core_max_mhz;
	} dsm_clk_cfg_s;
endpackage

// >>> dsm_supply_manager_monitor.sv
// port checker for the supply mode manager
`timescale 1ns/1ps
module dsm_supply_manager_monitor (
	input wire logic                  ref_clk_i,
	input wire logic                  rst_i,
	input wire logic                  sw_reset_i,
	input wire logic                  option_switch_pin_i,
	input wire logic                  plug_irq_enable_i,
	input wire logic [1:0]            regulator_voltage_select_i,
	input wire logic                  detector_disable_i,
	input wire logic                  regulator_enable_i,
	input wire logic                  supply_switch_enable_out_o,
	input wire logic                  supply_switch_enable_oe_o,
	input wire logic                  plug_irq_o,
	input wire logic [7:0]            power_control_reg_o,
	input wire logic                  usb_mode_o,
	input wire logic                  io_hiz_o,
	input wire logic                  clk_from_xtal_div_o,
	input wire dsm_pkg::dsm_clk_cfg_s clk_cfg_o,
	input wire logic [11:0]           regulator_mv_o
);
	wire            dual   = option_switch_pin_i & plug_irq_enable_i;
	wire [3:0][11:0] mv_tab = {12'hAF0, 12'hCE4, 12'hD48, 12'hDAC};
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////////////
	// stable inputs only: tolerates a registered millivolt output
	chk_mv_select: assert property ($stable(regulator_voltage_select_i) && regulator_enable_i
		&& $past(regulator_enable_i) |-> regulator_mv_o == mv_tab[regulator_voltage_select_i])
		else $error("regulator voltage wrong");
	chk_reset_zero: assert property (disable iff (1'b0) rst_i && !detector_disable_i
		|=> power_control_reg_o[7:5] == 3'h0) else $error("status flags not cleared by reset");
	chk_sa_clock: assert property (dual && !usb_mode_o |-> !clk_cfg_o.pll_on
		&& !clk_cfg_o.usb_if_enable && clk_cfg_o.core_max_mhz == 4'h6 && clk_from_xtal_div_o)
		else $error("stand-alone clock setup wrong");
	chk_usb_clock: assert property (usb_mode_o && !io_hiz_o |-> clk_cfg_o.pll_on
		&& clk_cfg_o.pll_mhz == 8'h30 && clk_cfg_o.core_max_mhz == 4'h8) else $error("usb clock wrong");
	chk_sa_float: assert property (dual && !usb_mode_o && !io_hiz_o |-> !supply_switch_enable_oe_o)
		else $error("switch pin driven in stand-alone");
	chk_usb_drive: assert property (dual && usb_mode_o |-> supply_switch_enable_oe_o
		&& !supply_switch_enable_out_o) else $error("switch pin not low in usb mode");
	chk_entry_drive: assert property (dual && sw_reset_i && !usb_mode_o && power_control_reg_o[5]
		##1 sw_reset_i |-> supply_switch_enable_oe_o && !supply_switch_enable_out_o)
		else $error("switch pin not low in entry reset");
	chk_reset_hiz: assert property (sw_reset_i ##1 sw_reset_i |-> io_hiz_o)
		else $error("io not high impedance in reset");
	chk_plug_irq: assert property ($rose(power_control_reg_o[5]) && plug_irq_enable_i
		&& !usb_mode_o |=> plug_irq_o) else $error("plug interrupt missing");
	chk_unplug_irq: assert property ($fell(power_control_reg_o[6]) && dual && usb_mode_o
		|=> plug_irq_o) else $error("unplug interrupt missing");
	cover property (dual && usb_mode_o);
	cover property ($rose(plug_irq_o));
	cover property ($fell(usb_mode_o) && dual);
endmodule
bind dsm_supply_manager dsm_supply_manager_monitor mon (.*);

// >>> dsm_supply_model.sv
// usb supply comparators and the external supply switch
`timescale 1ns/1ps
module dsm_supply_model #(
	parameter int FALL_CYCLES = 12
) (
	input  wire logic ref_clk_i,
	input  wire logic cable_i,
	input  wire logic pin_out_i,
	input  wire logic pin_oe_i,
	output logic      above_upper_o,
	output logic      above_lower_o,
	output logic      pin_o,
	output logic      switch_on_o
);
	int fall_cnt = 0;
	initial begin
		above_upper_o = 1'b0;
		above_lower_o = 1'b0;
	end
	// pull-up on the pin: released pin reads high, so the active-low switch stays off
	assign pin_o = pin_oe_i ? pin_out_i : 1'b1;
	assign switch_on_o = !pin_o;
	// the supply decays slowly: upper threshold is lost at once, lower only later
	always @(posedge ref_clk_i) begin
		above_upper_o <= cable_i;
		fall_cnt <= cable_i ? FALL_CYCLES : (fall_cnt > 0 ? fall_cnt - 1 : 0);
		above_lower_o <= cable_i || fall_cnt > 1;
	end
endmodule

// >>> dsm_supply_manager_tb.sv
// self-checking bench for the supply mode manager
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("BAD %s expected %h seen %h", n, e, g); end end
module dsm_supply_manager_tb;
	logic ref_clk_i = 1'b0, rst_i = 1'b1, sw_reset_i = 1'b0, option_switch_pin_i = 1'b0;
	logic plug_irq_enable_i = 1'b0, detector_disable_i = 1'b0, regulator_enable_i = 1'b0;
	logic switch_pin_alt_io_out_i = 1'b0, switch_pin_alt_io_oe_i = 1'b0, cable = 1'b0;
	logic [1:0]  regulator_voltage_select_i = 2'h0;
	logic        usb_supply_above_upper_i, usb_supply_above_lower_i, switch_pin_in_i, switch_on;
	logic        switch_pin_alt_io_in_o, supply_switch_enable_out_o, supply_switch_enable_oe_o;
	logic        plug_irq_o, usb_mode_o, io_hiz_o, clk_from_xtal_div_o, regulator_on_o;
	logic [7:0]  power_control_reg_o;
	logic [11:0] regulator_mv_o;
	logic [3:0][11:0] mv_tab = {12'hAF0, 12'hCE4, 12'hD48, 12'hDAC};
	dsm_pkg::dsm_clk_cfg_s clk_cfg_o;
	int miscompares = 0, num_checks = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	dsm_supply_manager dut (.*);
	dsm_supply_model model (.ref_clk_i(ref_clk_i), .cable_i(cable),
		.pin_out_i(supply_switch_enable_out_o), .pin_oe_i(supply_switch_enable_oe_o),
		.above_upper_o(usb_supply_above_upper_i), .above_lower_o(usb_supply_above_lower_i),
		.pin_o(switch_pin_in_i), .switch_on_o(switch_on));
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic wait_irq(input string n);
		int k;
		k = 0;
		while (plug_irq_o !== 1'b1 && k < 40) begin
			@(posedge ref_clk_i);
			#1;
			k++;
		end
		`CHK(n, 1'b1, plug_irq_o)
	endtask
	// reset held three edges so the transition state is surely seen
	task automatic mode_reset(input logic to_usb);
		@(posedge ref_clk_i);
		sw_reset_i <= 1'b1;
		tick(2);
		#1;
		`CHK("reset hiz", 1'b1, io_hiz_o)
		`CHK("reset switch", to_usb, switch_on)
		@(posedge ref_clk_i);
		sw_reset_i <= 1'b0;
		tick(2);
		#1;
		`CHK("mode", to_usb, usb_mode_o)
		`CHK("pll", {to_usb, to_usb ? 8'h30 : 8'h00}, {clk_cfg_o.pll_on, clk_cfg_o.pll_mhz})
		`CHK("xtal clock", !to_usb, clk_from_xtal_div_o)
		`CHK("switch", to_usb, switch_on)
		`CHK("irq cleared", 1'b0, plug_irq_o)
		$display("test mode change done");
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(3000);
		miscompares++;
		stop_test();
	end
	initial begin
		tick(6);
		rst_i <= 1'b0;
		tick(2);
		#1;
		`CHK("reset byte", 8'h00, power_control_reg_o)
		`CHK("single cfg", {2'h3, 8'h30, 1'b1, 4'h8}, {usb_mode_o, clk_cfg_o})
		`CHK("enable default", 1'b0, power_control_reg_o[4])
		@(posedge ref_clk_i);
		switch_pin_alt_io_oe_i <= 1'b1;
		tick(5);
		#1;
		`CHK("pin as io", 3'h4, {supply_switch_enable_oe_o, supply_switch_enable_out_o, switch_pin_alt_io_in_o})
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk_i);
			regulator_enable_i <= 1'b1;
			regulator_voltage_select_i <= i[1:0];
			tick(2);
			#1;
			`CHK("regulator mv", mv_tab[i], regulator_mv_o)
			`CHK("regulator on", 1'b1, regulator_on_o)
		end
		$display("test single supply done");
		@(posedge ref_clk_i);
		switch_pin_alt_io_oe_i <= 1'b0;
		option_switch_pin_i <= 1'b1;
		plug_irq_enable_i <= 1'b1;
		regulator_enable_i <= 1'b0;
		tick(2);
		#1;
		`CHK("stand-alone cfg", {1'b0, 1'b0, 4'h6}, {clk_cfg_o.pll_on, clk_cfg_o.usb_if_enable, clk_cfg_o.core_max_mhz})
		`CHK("pin floating", 1'b0, supply_switch_enable_oe_o)
		@(posedge ref_clk_i);
		cable <= 1'b1;
		wait_irq("plug irq");
		mode_reset(1'b1);
		@(posedge ref_clk_i);
		cable <= 1'b0;
		wait_irq("unplug irq");
		mode_reset(1'b0);
		@(posedge ref_clk_i);
		detector_disable_i <= 1'b1;
		wait_irq("forced plug irq");
		$display("test detector done");
		stop_test();
	end
endmodule
